// ---- ebc_pkg.sv ----
// =============================================================
// External bus cycle control: shared constants
// =============================================================
// Constants for the bus sequencer and its configuration port.
// Assumes a single core clock domain of 125 MHz.
package ebc_pkg;
   // Register indices on the configuration port
   localparam logic [2:0] WIN_CFG0_IDX  = 3'h0;
   localparam logic [2:0] WIN_CFG3_IDX  = 3'h3;
   localparam logic [2:0] STATUS_IDX    = 3'h4;
   // Fields of window_timing_config
   localparam int AB_LONG_BIT  = 0;
   localparam int AB_EXT_LSB   = 1;
   localparam int C_LSB        = 3;
   localparam int D_BIT        = 5;
   localparam int E_LSB        = 6;
   localparam int F_LSB        = 11;
   localparam int RDY_EN_BIT   = 13;
   localparam int RDY_POL_BIT  = 14;
   localparam int RDY_ASYNC_BIT = 15;
   // Reset value of every window: 2+0 setup, 0 delay, 0 setup, 1 access
   localparam logic [15:0] WIN_CFG_RST = 16'h0001;
   // Bus clock half period in core cycles (160 ns period at 8 ns)
   localparam int BUS_CLOCK_PERIOD_NS = 160;
   localparam int CORE_PERIOD_NS      = 8;
   localparam int HALF_DIV = BUS_CLOCK_PERIOD_NS / CORE_PERIOD_NS / 2;
   // Bus sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_AB, ST_C, ST_D, ST_E, ST_F, ST_REL, ST_HELD, ST_REGAIN
   } bus_state_t;
endpackage : ebc_pkg

// ---- external_bus_cycle_control.sv ----
// =============================================================
// External bus cycle control
// =============================================================
// Sequencer for external bus cycles and bus arbitration.
// Assumes pins are asynchronous to ref_clk; requests come from core logic.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module external_bus_cycle_control #(
   parameter int HALF_DIV = ebc_pkg::HALF_DIV
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Configuration port
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   // Core request side
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic [1:0]  req_window,
   input  wire logic [23:0] req_addr,
   input  wire logic        req_ube_n,
   input  wire logic [15:0] req_wdata,
   output logic             req_taken,
   output logic             req_done,
   output logic      [15:0] req_rdata,
   // External bus pins
   output logic             bus_reference_clock,
   output logic      [23:0] bus_addr,
   output logic             upper_byte_enable_n,
   output logic             ale,
   output logic             rd_n,
   output logic             wr_n,
   output logic             ctrl_oe,
   output logic      [15:0] data_out,
   output logic             data_oe,
   input  wire logic [15:0] data_in,
   input  wire logic        ready_in,
   // Arbitration pins
   input  wire logic        hold_n,
   output logic             bus_hold_ack_n,
   output logic             bus_regain_request_n
);
   initial begin
      if (HALF_DIV < 2 || HALF_DIV > 255) $error("HALF_DIV out of range");
   end

   typedef struct packed {
      logic [7:0]             div;
      logic                   clk;
      ebc_pkg::bus_state_t    st;
      logic [4:0]             cnt;
      logic [1:0]             win;
      logic [1:0]             last_win;
      logic                   wr;
      logic [3:0][15:0]       cfg;
      logic [15:0]            rdata;
      logic [1:0]             hold_s;
      logic [2:0]             rdy_s;
      logic                   rdy_t;
      logic [15:0]            din_s1;
      logic [15:0]            din_s2;
      logic                   taken;
      logic                   done;
      logic [15:0]            req_rd;
      logic [23:0]            addr;
      logic                   ube_n;
      logic                   ale;
      logic                   rd_n;
      logic                   wr_n;
      logic                   ctrl_oe;
      logic [15:0]            dout;
      logic                   doe;
      logic                   ack_n;
      logic                   bus_regain_request_n_n;
   } ebc_state_t;

   ebc_state_t s_r;
   ebc_state_t s_nxt;

   // Current window fields
   logic [15:0] wc;
   logic        tick;
   logic        rdy_lvl;
   logic        rdy_act;
   logic [1:0]  ab_len;
   logic [2:0]  ab_tot;

   // Field decode of the window in use
   always_comb begin
      wc      = s_r.cfg[s_r.win];
      tick    = (s_r.div == 8'(HALF_DIV - 1)) && s_r.clk; // Bus clock period end
      rdy_lvl = wc[ebc_pkg::RDY_ASYNC_BIT] ? s_r.rdy_t : s_r.rdy_s[1];
      rdy_act = (rdy_lvl == wc[ebc_pkg::RDY_POL_BIT]);
      ab_len  = wc[ebc_pkg::AB_EXT_LSB +: 2];
      ab_tot  = 3'(wc[ebc_pkg::AB_LONG_BIT]) + 3'(1)
              + ((s_r.win != s_r.last_win) ? 3'(ab_len) : 3'(0));
   end

   // Next state of the whole block
   always_comb begin
      s_nxt        = s_r;
      s_nxt.taken  = 1'b0;
      s_nxt.done   = 1'b0;
      // Pin synchronisers; ready has a third stage for async mode
      s_nxt.hold_s = {s_r.hold_s[0], hold_n};
      s_nxt.rdy_s  = {s_r.rdy_s[1:0], ready_in};
      // Async ready is seen one bus period late: one wait state more
      if (tick) begin
         s_nxt.rdy_t = s_r.rdy_s[2];
      end
      s_nxt.din_s1 = data_in;
      s_nxt.din_s2 = s_r.din_s1;
      // Free running bus clock divider
      if (s_r.div == 8'(HALF_DIV - 1)) begin
         s_nxt.div = 8'h00;
         s_nxt.clk = ~s_r.clk;
      end else begin
         s_nxt.div = s_r.div + 8'h01;
      end
      // Configuration writes and reads
      s_nxt.rdata = 16'h0000;
      if (reg_wr && reg_addr <= ebc_pkg::WIN_CFG3_IDX) begin
         s_nxt.cfg[reg_addr[1:0]] = reg_wdata;
      end
      if (reg_rd) begin
         if (reg_addr <= ebc_pkg::WIN_CFG3_IDX) begin
            s_nxt.rdata = s_r.cfg[reg_addr[1:0]];
         end else if (reg_addr == ebc_pkg::STATUS_IDX) begin
            s_nxt.rdata = {10'h000, s_r.bus_regain_request_n_n, s_r.ack_n, 4'(s_r.st)};
         end
      end
      // Sequencer advances only at bus clock period ends
      if (tick) begin
         case (s_r.st)
            ebc_pkg::ST_IDLE: begin
               if (!s_r.hold_s[1]) begin
                  s_nxt.st  = ebc_pkg::ST_REL; // Hold only taken between cycles
                  s_nxt.rd_n = 1'b1;
                  s_nxt.wr_n = 1'b1;
                  s_nxt.ale  = 1'b0;
               end else if (req_valid) begin
                  s_nxt.taken = 1'b1;
                  s_nxt.win   = req_window;
                  s_nxt.wr    = req_write;
                  s_nxt.addr  = req_addr;
                  s_nxt.ube_n = req_ube_n;
                  s_nxt.dout  = req_wdata;
                  s_nxt.ale   = 1'b1;
                  s_nxt.st    = ebc_pkg::ST_AB;
                  s_nxt.cnt   = 5'h1f; // Reload after window is known
               end
            end
            ebc_pkg::ST_AB: begin
               if (s_r.cnt == 5'h1f) begin
                  s_nxt.cnt = 5'(ab_tot) - 5'h02; // First period already spent
                  if (ab_tot == 3'(1)) begin
                     s_nxt.cnt = 5'h00;
                  end
                  if (ab_tot == 3'(1)) begin
                     s_nxt.ale = 1'b0;
                     s_nxt.st  = ebc_pkg::ST_C;
                     s_nxt.cnt = 5'(wc[ebc_pkg::C_LSB +: 2]);
                  end
               end else if (s_r.cnt == 5'h00) begin
                  s_nxt.ale = 1'b0;
                  s_nxt.st  = ebc_pkg::ST_C;
                  s_nxt.cnt = 5'(wc[ebc_pkg::C_LSB +: 2]);
               end else begin
                  s_nxt.cnt = s_r.cnt - 5'h01;
               end
            end
            ebc_pkg::ST_C: begin
               // Count holds remaining delay periods, last one ends the phase
               if (s_r.cnt == 5'h01) begin
                  s_nxt.st  = ebc_pkg::ST_D;
                  s_nxt.cnt = 5'(wc[ebc_pkg::D_BIT]);
                  s_nxt.doe = s_r.wr;
                  if (!wc[ebc_pkg::D_BIT]) begin
                     s_nxt.st   = ebc_pkg::ST_E;
                     s_nxt.cnt  = wc[ebc_pkg::E_LSB +: 5];
                     s_nxt.rd_n = s_r.wr;
                     s_nxt.wr_n = ~s_r.wr;
                  end
               end else begin
                  s_nxt.cnt = s_r.cnt - 5'h01;
               end
            end
            ebc_pkg::ST_D: begin
               s_nxt.st   = ebc_pkg::ST_E;
               s_nxt.cnt  = wc[ebc_pkg::E_LSB +: 5];
               s_nxt.rd_n = s_r.wr;
               s_nxt.wr_n = ~s_r.wr;
            end
            ebc_pkg::ST_E: begin
               if (s_r.cnt != 5'h00) begin
                  s_nxt.cnt = s_r.cnt - 5'h01; // Mandatory waits
               end else if (!wc[ebc_pkg::RDY_EN_BIT] || rdy_act) begin
                  // Strobe rises on the edge that latches read data
                  s_nxt.rd_n   = 1'b1;
                  s_nxt.wr_n   = 1'b1;
                  s_nxt.req_rd = s_r.din_s2;
                  s_nxt.st     = ebc_pkg::ST_F;
                  s_nxt.cnt    = 5'(wc[ebc_pkg::F_LSB +: 2]);
                  if (wc[ebc_pkg::F_LSB +: 2] == 2'b00) begin
                     s_nxt.st       = ebc_pkg::ST_IDLE;
                     s_nxt.doe      = 1'b0;
                     s_nxt.done     = 1'b1;
                     s_nxt.last_win = s_r.win;
                  end
               end
               // Otherwise a ready wait state is inserted
            end
            ebc_pkg::ST_F: begin
               if (s_r.cnt == 5'h01) begin
                  s_nxt.st       = ebc_pkg::ST_IDLE;
                  s_nxt.doe      = 1'b0;
                  s_nxt.done     = 1'b1;
                  s_nxt.last_win = s_r.win;
               end else begin
                  s_nxt.cnt = s_r.cnt - 5'h01;
               end
            end
            ebc_pkg::ST_REL: begin
               // Controls were driven inactive for one period, now float
               s_nxt.ctrl_oe = 1'b0;
               s_nxt.ack_n   = 1'b0;
               s_nxt.st      = ebc_pkg::ST_HELD;
            end
            ebc_pkg::ST_HELD: begin
               s_nxt.bus_regain_request_n_n = ~req_valid;
               if (s_r.hold_s[1]) begin
                  s_nxt.st      = ebc_pkg::ST_REGAIN;
                  s_nxt.ack_n   = 1'b1;
                  s_nxt.bus_regain_request_n_n  = 1'b1;
               end
            end
            ebc_pkg::ST_REGAIN: begin
               s_nxt.ctrl_oe = 1'b1; // Drive inactive before next cycle
               s_nxt.rd_n    = 1'b1;
               s_nxt.wr_n    = 1'b1;
               s_nxt.ale     = 1'b0;
               s_nxt.st      = ebc_pkg::ST_IDLE;
            end
            default: begin
               s_nxt.st = ebc_pkg::ST_IDLE;
            end
         endcase
      end
      // A zero command delay closes the delay phase at once
      if (tick && s_r.st == ebc_pkg::ST_AB && s_nxt.st == ebc_pkg::ST_C
          && s_nxt.cnt == 5'h00) begin
         s_nxt.st  = ebc_pkg::ST_D;
         s_nxt.cnt = 5'(wc[ebc_pkg::D_BIT]);
         s_nxt.doe = s_r.wr;
         if (!wc[ebc_pkg::D_BIT]) begin
            s_nxt.st   = ebc_pkg::ST_E;
            s_nxt.cnt  = wc[ebc_pkg::E_LSB +: 5];
            s_nxt.rd_n = s_r.wr;
            s_nxt.wr_n = ~s_r.wr;
         end
      end
      // Read data updates at the strobe rise, ahead of the completion pulse if the F phase is nonzero
      if (!s_nxt.done) begin
         s_nxt.req_rd = (s_r.st == ebc_pkg::ST_E) ? s_nxt.req_rd : s_r.req_rd;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         s_r          <= '0;
         s_r.st       <= ebc_pkg::ST_IDLE;
         s_r.cfg      <= {4{ebc_pkg::WIN_CFG_RST}};
         s_r.hold_s   <= 2'b11;
         s_r.rd_n     <= 1'b1;
         s_r.wr_n     <= 1'b1;
         s_r.ube_n    <= 1'b1;
         s_r.ctrl_oe  <= 1'b1;
         s_r.ack_n    <= 1'b1;
         s_r.bus_regain_request_n_n   <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata            = s_r.rdata;
   assign req_taken            = s_r.taken;
   assign req_done             = s_r.done;
   assign req_rdata            = s_r.req_rd;
   assign bus_reference_clock  = s_r.clk;
   assign bus_addr             = s_r.addr;
   assign upper_byte_enable_n  = s_r.ube_n;
   assign ale                  = s_r.ale;
   assign rd_n                 = s_r.rd_n;
   assign wr_n                 = s_r.wr_n;
   assign ctrl_oe              = s_r.ctrl_oe;
   assign data_out             = s_r.dout;
   assign data_oe              = s_r.doe;
   assign bus_hold_ack_n       = s_r.ack_n;
   assign bus_regain_request_n = s_r.bus_regain_request_n_n;
endmodule : external_bus_cycle_control

// ---- ebc_properties.sv ----
// Assertions on the pins of external_bus_cycle_control
// Bound onto the design; watches its ports only
`timescale 1ns/1ps
// ==========
// Checker
module ebc_properties #(
   parameter int HALF_DIV = 2
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Core and bus pins
   input wire logic req_taken,
   input wire logic req_done,
   input wire logic bus_reference_clock,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic ctrl_oe,
   input wire logic data_oe,
   // Arbitration
   input wire logic hold_n,
   input wire logic bus_hold_ack_n,
   input wire logic bus_regain_request_n
);
   logic [7:0] age_r;
   logic       clk_q_r;
   logic       seen_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Core cycles since the bus clock last changed
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         age_r   <= 8'h00;
         clk_q_r <= 1'b0;
         seen_r  <= 1'b0;
      end else begin
         age_r   <= (bus_reference_clock != clk_q_r) ? 8'h00 : age_r + 8'h01;
         clk_q_r <= bus_reference_clock;
         seen_r  <= seen_r | (bus_reference_clock != clk_q_r);
      end
   end
   a_clock_period: assert property (age_r < (seen_r ? HALF_DIV : 2 * HALF_DIV))
      else $error("bus clock half period wrong");
   a_cycle_completes: assert property (req_taken |-> ##[2:1000] req_done)
      else $error("bus cycle not finished");
   a_release_between_cycles: assert property ($fell(bus_hold_ack_n) |->
      rd_n && wr_n && !ale && !data_oe) else $error("bus given up mid cycle");
   a_float_while_held: assert property (!bus_hold_ack_n |-> !ctrl_oe && !req_taken)
      else $error("controls driven while held");
   a_drive_before_float: assert property ($fell(ctrl_oe) |->
      $past(rd_n) && $past(wr_n) && !$past(ale)) else $error("float without idle drive");
   a_regain_inactive: assert property ($rose(ctrl_oe) |->
      bus_hold_ack_n && rd_n && wr_n && !ale) else $error("regain not inactive");
   a_request_after_ack: assert property (!bus_regain_request_n |-> !bus_hold_ack_n)
      else $error("bus request without grant");
   a_regain_on_hold: assert property ($rose(bus_hold_ack_n) |-> $past(hold_n, 2))
      else $error("regain while hold low");
endmodule : ebc_properties

bind external_bus_cycle_control ebc_properties #(.HALF_DIV(HALF_DIV)) u_ebc_properties (
   .ref_clk(ref_clk), .resetn(resetn), .req_taken(req_taken), .req_done(req_done),
   .bus_reference_clock(bus_reference_clock), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
   .ctrl_oe(ctrl_oe), .data_oe(data_oe), .hold_n(hold_n), .bus_hold_ack_n(bus_hold_ack_n),
   .bus_regain_request_n(bus_regain_request_n));

// ---- ebc_memory_model.sv ----
// Behavioural external memory with a ready handshake
// Floated strobes read high through pull-ups
`timescale 1ns/1ps
// ==========
// Memory model
module ebc_memory_model (
   // Device pins
   input  wire logic        bus_reference_clock,
   input  wire logic [23:0] bus_addr,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic        ctrl_oe,
   input  wire logic [15:0] data_out,
   input  wire logic        data_oe,
   output logic      [15:0] data_in,
   output logic             ready_in,
   // Bench controls
   input  wire logic [3:0]  rdy_delay,
   input  wire logic        rdy_pol
);
   logic [15:0] mem [0:15];
   logic [3:0]  cnt_r = 4'h0;
   logic        rdy_r = 1'b0;
   wire         rd_w = ctrl_oe ? rd_n : 1'b1;
   wire         wr_w = ctrl_oe ? wr_n : 1'b1;
   wire         act = !(rd_w && wr_w);
   // Write data stored while the write strobe is low
   always @* begin
      if (!wr_w && data_oe) mem[bus_addr[3:0]] = data_out;
   end
   // Ready counts bus periods of the strobe, moves on the rising bus clock
   always @(posedge bus_reference_clock) begin
      cnt_r <= act ? cnt_r + 4'h1 : 4'h0;
      rdy_r <= act && (cnt_r >= rdy_delay);
   end
   // Ready dropped at the trailing strobe edge; data inverted outside reads
   assign ready_in = (rdy_r && act) ? rdy_pol : !rdy_pol;
   assign data_in  = rd_w ? ~mem[bus_addr[3:0]] : mem[bus_addr[3:0]];
endmodule : ebc_memory_model

// ---- tb.sv ----
// Self-checking bench for external_bus_cycle_control
// Memory model answers on the bus; bench plays core and other master
`timescale 1ns/1ps
// ==========
// Bench top
module tb;
   localparam int P = 20;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [2:0]  reg_addr = 3'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic [1:0]  req_window = 2'h0;
   logic [23:0] req_addr = 24'h00_0000;
   logic [15:0] req_wdata = 16'h0000;
   logic        hold_n = 1'b1;
   logic [3:0]  rdy_delay = 4'h0;
   logic        rdy_pol = 1'b1;
   logic [15:0] reg_rdata, req_rdata, data_out, data_in;
   logic [23:0] bus_addr;
   logic        req_taken, req_done, bus_reference_clock, ube_n, ale, rd_n, wr_n;
   logic        ctrl_oe, data_oe, ready_in, hold_ack_n, regain_n;
   logic [15:0] cfg [0:3] = '{16'h0000, 16'h1FFF, 16'h684A, 16'hA004};
   logic [1:0]  seq [0:5] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2};
   logic [2:0]  pv = 3'b100;
   int          t [0:5];
   int          cyc = 0;
   int          fails = 0;
   int          checks = 0;
   int          i, n, ab;
   logic [1:0]  w;
   // Core clock
   always #4 ref_clk = ~ref_clk;
   external_bus_cycle_control #(.HALF_DIV(10)) u_external_bus_cycle_control (
      .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
      .req_write(req_write), .req_window(req_window), .req_addr(req_addr),
      .req_ube_n(1'b0), .req_wdata(req_wdata), .req_taken(req_taken), .req_done(req_done),
      .req_rdata(req_rdata), .bus_reference_clock(bus_reference_clock), .bus_addr(bus_addr),
      .upper_byte_enable_n(ube_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ctrl_oe(ctrl_oe),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in), .ready_in(ready_in),
      .hold_n(hold_n), .bus_hold_ack_n(hold_ack_n), .bus_regain_request_n(regain_n));
   ebc_memory_model u_ebc_memory_model (
      .bus_reference_clock(bus_reference_clock), .bus_addr(bus_addr), .rd_n(rd_n),
      .wr_n(wr_n), .ctrl_oe(ctrl_oe), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_in), .ready_in(ready_in), .rdy_delay(rdy_delay), .rdy_pol(rdy_pol));
   // Edge times of ale, data enable and strobes
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      pv  <= {rd_n & wr_n, data_oe, ale};
      if (ale & !pv[0]) t[0] <= cyc;
      if (!ale & pv[0]) t[1] <= cyc;
      if (data_oe & !pv[1]) t[2] <= cyc;
      if (!(rd_n & wr_n) & pv[2]) t[3] <= cyc;
      if ((rd_n & wr_n) & !pv[2]) t[4] <= cyc;
      if (!data_oe & pv[1]) t[5] <= cyc;
   end
   task automatic conclude();
      if (fails == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tmo(input int k);
      if (k >= 5000) begin
         fails++;
         $display("Error %0t: wait ran out", $time);
         conclude();
      end
   endtask : tmo
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      chk(reg_rdata, exp);
   endtask : rd
   task automatic bus(input logic we, input logic [1:0] win, input logic [23:0] a,
                      input logic [15:0] d);
      int k;
      @(posedge ref_clk);
      req_valid  <= 1'b1;
      req_write  <= we;
      req_window <= win;
      req_addr   <= a;
      req_wdata  <= d;
      for (k = 0; k < 5000 && req_taken !== 1'b1; k++) @(posedge ref_clk);
      tmo(k);
      req_valid <= 1'b0;
      for (k = 0; k < 5000 && req_done !== 1'b1; k++) @(posedge ref_clk);
      tmo(k);
      @(posedge ref_clk);
   endtask : bus
   // Main sequence
   initial begin
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      for (i = 0; i < 4; i++) rd(3'(i), 16'h0001);
      for (i = 0; i < 4; i++) wr(3'(i), cfg[i]);
      wr(3'h5, 16'hFFFF);
      rd(3'h5, 16'h0000);
      for (i = 0; i < 4; i++) rd(3'(i), cfg[i]);
      for (i = 0; i < 6; i++) begin
         w = seq[i];
         bus(1'b1, w, 24'(i), 16'h1000 + 16'(i));
         if (i > 0) begin
            ab = 1 + int'(cfg[w][0]) + ((w != seq[i-1]) ? int'(cfg[w][2:1]) : 0);
            chk(16'(t[1] - t[0]), 16'(ab * P));
            chk(16'(t[2] - t[1]), 16'(int'(cfg[w][4:3]) * P));
            chk(16'(t[3] - t[2]), 16'(int'(cfg[w][5]) * P));
            chk(16'(t[4] - t[3]), 16'((int'(cfg[w][10:6]) + 1) * P));
            chk(16'(t[5] - t[4]), 16'(int'(cfg[w][12:11]) * P));
         end
      end
      for (i = 1; i < 6; i++) begin
         bus(1'b0, seq[i], 24'(i), 16'h0000);
         chk(req_rdata, 16'h1000 + 16'(i));
      end
      rdy_pol <= 1'b0;
      bus(1'b0, 2'h3, 24'h00_0005, 16'h0000);
      chk(16'(t[4] - t[3] >= 2 * P), 16'h0001);
      chk(req_rdata, 16'h1005);
      rdy_delay <= 4'h3;
      bus(1'b0, 2'h3, 24'h00_0005, 16'h0000);
      chk(16'(t[4] - t[3] > 3 * P), 16'h0001);
      fork
         bus(1'b0, 2'h1, 24'h00_0002, 16'h0000);
         begin
            for (n = 0; n < 5000 && req_taken !== 1'b1; n++) @(posedge ref_clk);
            tmo(n);
            repeat (12) @(posedge ref_clk);
            hold_n <= 1'b0;
         end
      join
      chk(req_rdata, 16'h1002);
      for (n = 0; n < 5000 && hold_ack_n !== 1'b0; n++) @(posedge ref_clk);
      tmo(n);
      chk(16'(ctrl_oe), 16'h0000);
      rd(3'h4, 16'h0027);
      fork
         bus(1'b0, 2'h0, 24'h00_0001, 16'h0000);
         begin
            for (n = 0; n < 5000 && regain_n !== 1'b0; n++) @(posedge ref_clk);
            tmo(n);
            hold_n <= 1'b1;
         end
      join
      chk(req_rdata, 16'h1001);
      @(posedge ref_clk);
      hold_n <= 1'b0;
      for (n = 0; n < 5000 && hold_ack_n !== 1'b0; n++) @(posedge ref_clk);
      tmo(n);
      hold_n <= 1'b1;
      for (n = 0; n < 5000 && hold_ack_n !== 1'b1; n++) @(posedge ref_clk);
      tmo(n);
      bus(1'b0, 2'h0, 24'h00_0004, 16'h0000);
      chk(req_rdata, 16'h1004);
      conclude();
   end
endmodule : tb
